// *** verilog/mrs_slave.sv ***
// Modbus RTU slave front end: settings, frame parser, responder, indicators
`timescale 1ns/1ps
`include "mrs_consts.svh"
module mrs_slave #(
  parameter int LED_HOLD_CYC = `MRS_LED_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] DIP_SW,
  input wire logic USB_MODE,
  input wire logic [7:0] NV_ADDR,
  input wire logic [15:0] NV_BAUD_DIV,
  input wire logic [1:0] NV_PARITY,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  output logic [15:0] REG_ADDR,
  output logic [15:0] REG_WDATA,
  output logic REG_WE,
  output logic REG_RE,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_ERR,
  input wire logic [7:0] FAIL_COND,
  input wire logic [7:0] FAIL_MASK,
  output logic [7:0] SLAVE_ADDR,
  output logic [15:0] BAUD_DIV,
  output logic [1:0] PARITY,
  output logic NV_SAVE,
  output logic REBOOT,
  output logic LED_FAIL,
  output logic LED_RX,
  output logic LED_TX
);
  mrs_stream_if #(.W(8)) up_if ();
  mrs_stream_if #(.W(8)) dn_if ();

  // ==========================================================
  // Transmit buffer
  mrs_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .ce(CE),
    .up(up_if.snk),
    .dn(dn_if.src)
  );
  assign TX_VALID = dn_if.valid;
  assign TX_DATA = dn_if.data;
  assign dn_if.ready = TX_READY;

  // ==========================================================
  // Communication settings
  logic cfg_done_r, cfg_done_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [15:0] div_r, div_nxt;
  logic [1:0] par_r, par_nxt;
  logic boot_go;

  // Captured once after reset release, again only on a reboot command
  always_comb begin
    cfg_done_nxt = cfg_done_r;
    addr_nxt = addr_r;
    div_nxt = div_r;
    par_nxt = par_r;
    if (boot_go) begin
      cfg_done_nxt = 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_nxt = 1'b1;
      par_nxt = NV_PARITY;
      if (USB_MODE || DIP_SW == 8'h00) begin
        addr_nxt = (NV_ADDR == 8'h00 || NV_ADDR > `MRS_ADDR_MAX) ? `MRS_ADDR_DFLT : NV_ADDR;
        div_nxt = (NV_BAUD_DIV == 16'h0000) ? `MRS_DIV_9600 : NV_BAUD_DIV;
      end else begin
        addr_nxt = (DIP_SW[5:0] == 6'h00) ? `MRS_ADDR_DFLT : {2'b00, DIP_SW[5:0]};
        case (DIP_SW[7:6])
          2'h0: div_nxt = `MRS_DIV_9600;
          2'h1: div_nxt = `MRS_DIV_19200;
          2'h2: div_nxt = `MRS_DIV_38400;
          default: div_nxt = `MRS_DIV_57600;
        endcase
      end
    end
  end

  // Settings registers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cfg_done_r <= 1'b0;
      addr_r <= `MRS_ADDR_DFLT;
      div_r <= `MRS_DIV_9600;
      par_r <= `MRS_PAR_NONE;
    end else if (CE) begin
      cfg_done_r <= cfg_done_nxt;
      addr_r <= addr_nxt;
      div_r <= div_nxt;
      par_r <= par_nxt;
    end
  end
  assign SLAVE_ADDR = addr_r;
  assign BAUD_DIV = div_r;
  assign PARITY = par_r;

  // ==========================================================
  // Frame engine
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  mrs_pkg::mrs_state_t st_r, st_nxt;
  logic [7:0] fb_r [16];
  logic [7:0] fb_nxt [16];
  logic [4:0] nb_r, nb_nxt, idx_r, idx_nxt;
  logic [15:0] crc_r, crc_nxt, wd_r, wd_nxt, w_r, w_nxt;
  logic [7:0] exc_r, exc_nxt;
  logic [23:0] sil_r, sil_nxt;
  logic pend_r, pend_nxt, boot_r, boot_nxt, save_r, save_nxt;
  logic we_r, we_nxt, re_r, re_nxt;
  logic [15:0] ra_r, ra_nxt, wdat_r, wdat_nxt;
  logic [7:0] fc, tx_b;
  logic [15:0] start, qty;
  logic [16:0] end_a;
  logic [23:0] gap;
  logic tx_v, push;

  assign fc = fb_r[1];
  assign start = {fb_r[2], fb_r[3]};
  assign qty = {fb_r[4], fb_r[5]};
  assign end_a = {1'b0, start} + {1'b0, qty};
  assign gap = 24'(div_r) * `MRS_GAP_BITS;
  assign up_if.valid = tx_v;
  assign up_if.data = tx_b;
  assign push = tx_v && up_if.ready;
  assign boot_go = boot_r;

  // Next state of the parser and responder
  always_comb begin
    st_nxt = st_r;
    fb_nxt = fb_r;
    nb_nxt = nb_r;
    idx_nxt = idx_r;
    crc_nxt = crc_r;
    wd_nxt = wd_r;
    w_nxt = w_r;
    exc_nxt = exc_r;
    sil_nxt = sil_r;
    pend_nxt = pend_r;
    boot_nxt = 1'b0;
    save_nxt = 1'b0;
    we_nxt = 1'b0;
    re_nxt = 1'b0;
    ra_nxt = ra_r;
    wdat_nxt = wdat_r;
    tx_v = 1'b0;
    tx_b = 8'h00;
    case (st_r)
      mrs_pkg::S_IDLE: begin
        if (RX_VALID) begin
          fb_nxt[0] = RX_DATA;
          nb_nxt = 5'h01;
          crc_nxt = crc_step(`MRS_CRC_INIT, RX_DATA);
          sil_nxt = '0;
          st_nxt = mrs_pkg::S_RX;
        end
      end
      mrs_pkg::S_RX: begin
        if (RX_VALID) begin
          if (nb_r < `MRS_FRAME_MAX) begin
            fb_nxt[nb_r[3:0]] = RX_DATA;
          end
          if (nb_r <= `MRS_FRAME_MAX) begin
            nb_nxt = nb_r + 1'b1;
          end
          crc_nxt = crc_step(crc_r, RX_DATA);
          sil_nxt = '0;
        end else if (sil_r >= gap) begin
          st_nxt = mrs_pkg::S_CHECK;
        end else begin
          sil_nxt = sil_r + 1'b1;
        end
      end
      mrs_pkg::S_CHECK: begin
        idx_nxt = '0;
        w_nxt = '0;
        exc_nxt = `MRS_EXC_NONE;
        st_nxt = mrs_pkg::S_TXH;
        if (crc_r != 16'h0000 || fb_r[0] != addr_r || nb_r < `MRS_LEN_MIN
            || nb_r > `MRS_FRAME_MAX) begin
          st_nxt = mrs_pkg::S_IDLE;
        end else if (fc == `MRS_FC_RD) begin
          if (nb_r != `MRS_LEN_FIX || qty == 16'h0000 || qty > `MRS_RD_MAX) begin
            exc_nxt = `MRS_EXC_VAL;
          end else if (end_a > `MRS_REG_SPACE) begin
            exc_nxt = `MRS_EXC_ADDR;
          end
        end else if (fc == `MRS_FC_WR1) begin
          if (nb_r != `MRS_LEN_FIX) begin
            exc_nxt = `MRS_EXC_VAL;
          end else if ({1'b0, start} >= `MRS_REG_SPACE) begin
            exc_nxt = `MRS_EXC_ADDR;
          end else begin
            st_nxt = mrs_pkg::S_WR;
          end
        end else if (fc == `MRS_FC_WRN) begin
          if (qty == 16'h0000 || qty > `MRS_WR_MAX || {8'h00, fb_r[6]} != {qty[14:0], 1'b0}
              || nb_r != `MRS_LEN_WRN + fb_r[6][4:0]) begin
            exc_nxt = `MRS_EXC_VAL;
          end else if (end_a > `MRS_REG_SPACE) begin
            exc_nxt = `MRS_EXC_ADDR;
          end else begin
            st_nxt = mrs_pkg::S_WR;
          end
        end else begin
          exc_nxt = `MRS_EXC_FUNC;
        end
        crc_nxt = `MRS_CRC_INIT;
      end
      mrs_pkg::S_WR: begin
        we_nxt = 1'b1;
        ra_nxt = start + w_r;
        wdat_nxt = (fc == `MRS_FC_WR1) ? qty : {fb_r[7 + 2 * w_r[0]], fb_r[8 + 2 * w_r[0]]};
        if (start + w_r == `MRS_CMD_REG && wdat_nxt == `MRS_CMD_SAVE) begin
          save_nxt = 1'b1;
        end
        if (start + w_r == `MRS_CMD_REG && wdat_nxt == `MRS_CMD_BOOT) begin
          pend_nxt = 1'b1;
        end
        st_nxt = mrs_pkg::S_WRW;
      end
      mrs_pkg::S_WRW: begin
        if (REG_ERR) begin
          exc_nxt = `MRS_EXC_FAIL;
          st_nxt = mrs_pkg::S_TXH;
        end else if (fc == `MRS_FC_WRN && w_r + 1'b1 < qty) begin
          w_nxt = w_r + 1'b1;
          st_nxt = mrs_pkg::S_WR;
        end else begin
          w_nxt = '0;
          st_nxt = mrs_pkg::S_TXH;
        end
      end
      mrs_pkg::S_TXH: begin
        tx_v = 1'b1;
        case (idx_r)
          5'h00: tx_b = fb_r[0];
          5'h01: tx_b = (exc_r != `MRS_EXC_NONE) ? (fc | `MRS_EXC_FLAG) : fc;
          5'h02: tx_b = (exc_r != `MRS_EXC_NONE) ? exc_r
                        : (fc == `MRS_FC_RD) ? {qty[6:0], 1'b0} : fb_r[2];
          default: tx_b = fb_r[idx_r[3:0]];
        endcase
        if (push) begin
          crc_nxt = crc_step(crc_r, tx_b);
          idx_nxt = idx_r + 1'b1;
          if (idx_r == 5'h02 && (exc_r != `MRS_EXC_NONE || fc == `MRS_FC_RD)) begin
            st_nxt = (exc_r != `MRS_EXC_NONE) ? mrs_pkg::S_CRCL : mrs_pkg::S_RD;
            pend_nxt = pend_r && (exc_r == `MRS_EXC_NONE);
          end else if (idx_r == 5'h05) begin
            st_nxt = mrs_pkg::S_CRCL;
          end
        end
      end
      mrs_pkg::S_RD: begin
        re_nxt = 1'b1;
        ra_nxt = start + w_r;
        st_nxt = mrs_pkg::S_RDW;
      end
      mrs_pkg::S_RDW: begin
        if (!re_r) begin
          wd_nxt = REG_RDATA;
          idx_nxt = '0;
          st_nxt = mrs_pkg::S_TXD;
        end
      end
      mrs_pkg::S_TXD: begin
        tx_v = 1'b1;
        tx_b = idx_r[0] ? wd_r[7:0] : wd_r[15:8];
        if (push) begin
          crc_nxt = crc_step(crc_r, tx_b);
          idx_nxt = idx_r + 1'b1;
          if (idx_r[0]) begin
            w_nxt = w_r + 1'b1;
            st_nxt = (w_r + 1'b1 == qty) ? mrs_pkg::S_CRCL : mrs_pkg::S_RD;
          end
        end
      end
      mrs_pkg::S_CRCL: begin
        tx_v = 1'b1;
        tx_b = crc_r[7:0];
        if (push) begin
          st_nxt = mrs_pkg::S_CRCH;
        end
      end
      mrs_pkg::S_CRCH: begin
        tx_v = 1'b1;
        tx_b = crc_r[15:8];
        if (push) begin
          boot_nxt = pend_r;
          pend_nxt = 1'b0;
          st_nxt = mrs_pkg::S_IDLE;
        end
      end
      default: st_nxt = mrs_pkg::S_IDLE;
    endcase
  end

  // Frame engine registers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= mrs_pkg::S_IDLE;
      for (int i = 0; i < 16; i++) begin
        fb_r[i] <= 8'h00;
      end
      nb_r <= '0;
      idx_r <= '0;
      crc_r <= `MRS_CRC_INIT;
      wd_r <= '0;
      w_r <= '0;
      exc_r <= `MRS_EXC_NONE;
      sil_r <= '0;
      pend_r <= 1'b0;
      boot_r <= 1'b0;
      save_r <= 1'b0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      ra_r <= '0;
      wdat_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
      fb_r <= fb_nxt;
      nb_r <= nb_nxt;
      idx_r <= idx_nxt;
      crc_r <= crc_nxt;
      wd_r <= wd_nxt;
      w_r <= w_nxt;
      exc_r <= exc_nxt;
      sil_r <= sil_nxt;
      pend_r <= pend_nxt;
      boot_r <= boot_nxt;
      save_r <= save_nxt;
      we_r <= we_nxt;
      re_r <= re_nxt;
      ra_r <= ra_nxt;
      wdat_r <= wdat_nxt;
    end
  end
  assign REG_WE = we_r;
  assign REG_RE = re_r;
  assign REG_ADDR = ra_r;
  assign REG_WDATA = wdat_r;
  assign NV_SAVE = save_r;
  assign REBOOT = boot_r;

  // ==========================================================
  // Indicators
  logic [23:0] rxh_r, rxh_nxt, txh_r, txh_nxt;
  logic fail_r, fail_nxt, lrx_r, lrx_nxt, ltx_r, ltx_nxt;

  // Hold timers retrigger on each byte seen on the RS485 side
  always_comb begin
    fail_nxt = |(FAIL_COND & FAIL_MASK);
    rxh_nxt = (rxh_r != '0) ? rxh_r - 1'b1 : rxh_r;
    txh_nxt = (txh_r != '0) ? txh_r - 1'b1 : txh_r;
    if (RX_VALID && !USB_MODE) begin
      rxh_nxt = 24'(LED_HOLD_CYC);
    end
    if (TX_VALID && TX_READY && !USB_MODE) begin
      txh_nxt = 24'(LED_HOLD_CYC);
    end
    lrx_nxt = (rxh_nxt != '0);
    ltx_nxt = (txh_nxt != '0);
  end

  // Indicator registers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rxh_r <= '0;
      txh_r <= '0;
      fail_r <= 1'b0;
      lrx_r <= 1'b0;
      ltx_r <= 1'b0;
    end else if (CE) begin
      rxh_r <= rxh_nxt;
      txh_r <= txh_nxt;
      fail_r <= fail_nxt;
      lrx_r <= lrx_nxt;
      ltx_r <= ltx_nxt;
    end
  end
  assign LED_FAIL = fail_r;
  assign LED_RX = lrx_r;
  assign LED_TX = ltx_r;
endmodule

// *** shared/mrs_consts.svh ***
// Constants of the Modbus RTU slave front end
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH
// ==========================================================
// Clock and timing
`define MRS_CLK_HZ 125000000
`define MRS_LED_MS 20
`define MRS_LED_CYC (`MRS_LED_MS * (`MRS_CLK_HZ / 1000))
`define MRS_GAP_BITS 24'h000027
// ==========================================================
// Switch baud table, bit period in clock cycles
`define MRS_DIV_9600 16'((`MRS_CLK_HZ + 4800) / 9600)
`define MRS_DIV_19200 16'((`MRS_CLK_HZ + 9600) / 19200)
`define MRS_DIV_38400 16'((`MRS_CLK_HZ + 19200) / 38400)
`define MRS_DIV_57600 16'((`MRS_CLK_HZ + 28800) / 57600)
// ==========================================================
// Frame fields and codes
`define MRS_FC_RD 8'h03
`define MRS_FC_WR1 8'h06
`define MRS_FC_WRN 8'h10
`define MRS_EXC_FLAG 8'h80
`define MRS_EXC_NONE 8'h00
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VAL 8'h03
`define MRS_EXC_FAIL 8'h04
`define MRS_RD_MAX 16'h0010
`define MRS_WR_MAX 16'h0002
`define MRS_LEN_FIX 5'h08
`define MRS_LEN_WRN 5'h09
`define MRS_LEN_MIN 5'h04
`define MRS_FRAME_MAX 5'h10
// ==========================================================
// Addresses, commands, CRC
`define MRS_ADDR_MAX 8'hF7
`define MRS_ADDR_DFLT 8'h01
`define MRS_PAR_NONE 2'h0
`define MRS_CMD_REG 16'h0078
`define MRS_CMD_SAVE 16'hC1C0
`define MRS_CMD_BOOT 16'hC1A0
`define MRS_REG_SPACE 17'h00080
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`endif

// *** shared/mrs_pkg.sv ***
// Types of the Modbus RTU slave front end
package mrs_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_RX, S_CHECK, S_WR, S_WRW, S_TXH, S_RD, S_RDW, S_TXD, S_CRCL, S_CRCH
  } mrs_state_t;
endpackage

// *** shared/mrs_stream_if.sv ***
// Byte stream carrier between the slave and its transmit buffer
`timescale 1ns/1ps
interface mrs_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** verilog/mrs_buf.sv ***
// Small valid/ready buffer in the transmit byte path
`timescale 1ns/1ps
module mrs_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  mrs_stream_if.snk up,
  mrs_stream_if.src dn
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;
  logic vld_r;
  logic [W-1:0] dat_r;

  // ==========================================================
  // Handshakes, ready drops only when every entry is used; outputs come from flops
  assign up.ready = (cnt_r != FULL);
  assign dn.valid = vld_r;
  assign dn.data = dat_r;
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // Next pointers, count and storage
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = up.data;
      wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      vld_r <= 1'b0;
      dat_r <= '0;
    end else if (ce) begin
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      vld_r <= (cnt_nxt != '0);
      dat_r <= mem_nxt[rd_nxt];
    end
  end
endmodule

// *** bench/mrs_master_model.sv ***
// Far-side model: reply byte sink with stalls and register store responder
`timescale 1ns/1ps
module mrs_master_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic err_on,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  output logic reg_err
);
  logic [7:0] rx_q[$];
  logic [31:0] wr_q[$];
  initial tx_ready = 1'b0;
  // Collect reply bytes and register writes; stall at random when asked
  always @(posedge clk) begin
    if (rstn && tx_valid && tx_ready) rx_q.push_back(tx_data);
    if (rstn && reg_we) wr_q.push_back({reg_addr, reg_wdata});
    tx_ready <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
  end
  // zero-based word store, data valid only the cycle after the read strobe
  always @(posedge clk) begin
    reg_rdata <= reg_re ? {reg_addr[7:0] ^ 8'h5A, reg_addr[7:0]} : 16'h0000;
  end
  assign reg_err = err_on;
endmodule

// *** bench/mrs_slave_chk.sv ***
// Assertion checker for the Modbus RTU slave front end
`timescale 1ns/1ps
module mrs_slave_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic USB_MODE,
  input wire logic RX_VALID,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [7:0] FAIL_COND,
  input wire logic [7:0] FAIL_MASK,
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic [15:0] BAUD_DIV,
  input wire logic NV_SAVE,
  input wire logic REBOOT,
  input wire logic LED_FAIL,
  input wire logic LED_RX,
  input wire logic LED_TX
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic [2:0] quiet_r;
  // Cycles since reset or restart, saturating
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) quiet_r <= 3'h0;
    else if (REBOOT) quiet_r <= 3'h0;
    else if (quiet_r != 3'h4) quiet_r <= quiet_r + 3'h1;
  end
  // ==========================================================
  // Properties
  property p_fail_lamp; CE |=> LED_FAIL == |($past(FAIL_COND & FAIL_MASK)); endproperty
  property p_save_cmd;
    NV_SAVE |-> REG_WE && REG_ADDR == 16'h0078 && REG_WDATA == 16'hC1C0;
  endproperty
  property p_boot_pulse; REBOOT |=> !REBOOT [*3]; endproperty
  property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  property p_reg_range; REG_RE || REG_WE |-> REG_ADDR < 16'h0080; endproperty
  property p_wr_space; REG_WE |=> !REG_WE; endproperty
  property p_rx_lamp; CE && RX_VALID && !USB_MODE |=> LED_RX; endproperty
  property p_tx_lamp; TX_VALID && TX_READY && !USB_MODE |-> ##[0:2] LED_TX; endproperty
  property p_settings_hold;
    quiet_r == 3'h4 && !REBOOT |=> $stable(SLAVE_ADDR) && $stable(BAUD_DIV);
  endproperty
  property p_addr_legal; SLAVE_ADDR inside {[8'h01:8'hF7]}; endproperty
  a_fail_lamp: assert property (p_fail_lamp) else $error("fail lamp wrong");
  a_save_cmd: assert property (p_save_cmd) else $error("save without command");
  a_boot_pulse: assert property (p_boot_pulse) else $error("restart pulse long");
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte lost");
  a_reg_range: assert property (p_reg_range) else $error("register index out");
  a_wr_space: assert property (p_wr_space) else $error("writes too close");
  a_rx_lamp: assert property (p_rx_lamp) else $error("rx lamp dark");
  a_tx_lamp: assert property (p_tx_lamp) else $error("tx lamp dark");
  a_settings_hold: assert property (p_settings_hold) else $error("settings moved");
  a_addr_legal: assert property (p_addr_legal) else $error("address illegal");
  c_boot: cover property (REBOOT);
  c_save: cover property (NV_SAVE);
  c_stall: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
endmodule
bind mrs_slave mrs_slave_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE),
  .USB_MODE(USB_MODE), .RX_VALID(RX_VALID), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_READY(TX_READY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
  .REG_RE(REG_RE), .FAIL_COND(FAIL_COND), .FAIL_MASK(FAIL_MASK), .SLAVE_ADDR(SLAVE_ADDR),
  .BAUD_DIV(BAUD_DIV), .NV_SAVE(NV_SAVE), .REBOOT(REBOOT), .LED_FAIL(LED_FAIL),
  .LED_RX(LED_RX), .LED_TX(LED_TX));

// *** bench/modbus_rtu_slave_config_port_test.sv ***
// Self-checking bench of the Modbus RTU slave front end
`timescale 1ns/1ps
module modbus_rtu_slave_config_port_test;
  localparam logic [7:0] ME = 8'h11;
  logic clk_sys = 1'b0, rstn = 1'b0, usb_mode = 1'b0, rx_valid = 1'b0;
  logic stall = 1'b0, err_on = 1'b0;
  logic [7:0] dip_sw = 8'h00, rx_data = 8'h00, fail_cond = 8'h00, fail_mask = 8'h00;
  logic tx_valid, tx_ready, reg_we, reg_re, reg_err, nv_save, reboot, led_fail, led_rx, led_tx;
  logic [7:0] tx_data, slave_addr;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, baud_div;
  logic [1:0] parity;
  int mismatches = 0, check_count = 0, save_n = 0, boot_n = 0;
  always #4 clk_sys = ~clk_sys;
  mrs_slave #(.LED_HOLD_CYC(8)) u_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1),
    .DIP_SW(dip_sw), .USB_MODE(usb_mode), .NV_ADDR(ME), .NV_BAUD_DIV(16'h0004),
    .NV_PARITY(2'h0), .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .REG_ERR(reg_err),
    .FAIL_COND(fail_cond), .FAIL_MASK(fail_mask), .SLAVE_ADDR(slave_addr),
    .BAUD_DIV(baud_div), .PARITY(parity), .NV_SAVE(nv_save), .REBOOT(reboot),
    .LED_FAIL(led_fail), .LED_RX(led_rx), .LED_TX(led_tx));
  mrs_master_model u_master (.clk(clk_sys), .rstn(rstn), .stall(stall), .err_on(err_on),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .reg_err(reg_err));
  // Count command pulses
  always @(posedge clk_sys) begin
    if (rstn && nv_save === 1'b1) save_n++;
    if (rstn && reboot === 1'b1) boot_n++;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, expd, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic [15:0] rdv(input logic [15:0] a);
    return {a[7:0] ^ 8'h5A, a[7:0]};
  endfunction
  function automatic logic [15:0] div_of(input logic [1:0] code);
    int r;
    r = (code == 2'h0) ? 9600 : (code == 2'h1) ? 19200 : (code == 2'h2) ? 38400 : 57600;
    return 16'((125000000 + r / 2) / r);
  endfunction
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // Reset with given switches, then move them and see settings stay
  task automatic sw_case(input logic [7:0] sw, input logic usb, input logic [7:0] ea,
    input logic [15:0] ed);
    @(posedge clk_sys);
    dip_sw <= sw;
    usb_mode <= usb;
    do_reset();
    chk("slave_addr", slave_addr, ea);
    chk("baud_div", baud_div, ed);
    chk("parity", parity, 2'h0);
    @(posedge clk_sys);
    dip_sw <= ~sw;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("addr_held", slave_addr, ea);
    chk("div_held", baud_div, ed);
  endtask
  // Send a request with CRC, expect the reply with CRC or none
  task automatic req(input logic [7:0] f[$], input logic [7:0] r[$], input bit bad);
    logic [15:0] c;
    int n;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    if (r.size() > 0) begin
      c = crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    @(posedge clk_sys);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data <= f[i];
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    #1;
    chk("led_rx", led_rx, 1'b1);
    n = 0;
    while (u_master.rx_q.size() < r.size() && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) begin
      mismatches++;
      wrap_up();
    end
    repeat (400) @(posedge clk_sys);
    chk("reply_len", u_master.rx_q.size(), r.size());
    foreach (r[i]) if (i < u_master.rx_q.size()) chk("reply_byte", u_master.rx_q[i], r[i]);
    u_master.rx_q.delete();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int a, s, cnt;
    logic [15:0] v;
    logic [7:0] q[$], r[$], e[$], fcs[3];
    void'($urandom(32'h27a57542));
    for (int k = 0; k < 4; k++) begin
      a = $urandom_range(1, 63);
      sw_case({k[1:0], a[5:0]}, 1'b0, 8'(a), div_of(k[1:0]));
    end
    sw_case(8'hFF, 1'b0, 8'h3F, div_of(2'h3));
    sw_case(8'h40, 1'b0, 8'h01, div_of(2'h1));
    sw_case(8'hC5, 1'b1, ME, 16'h0004);
    sw_case(8'h00, 1'b0, ME, 16'h0004);
    @(posedge clk_sys);
    dip_sw <= 8'h00;
    stall <= 1'b1;
    // random read, top boundary and a third
    for (int k = 0; k < 3; k++) begin
      cnt = (k == 1) ? 16 : $urandom_range(1, 16);
      s = (k == 1) ? 128 - cnt : $urandom_range(0, 128 - cnt);
      q = {ME, 8'h03, 8'h00, 8'(s), 8'h00, 8'(cnt)};
      r = {ME, 8'h03, 8'(2 * cnt)};
      for (int i = 0; i < cnt; i++) begin
        v = rdv(16'(s + i));
        r.push_back(v[15:8]);
        r.push_back(v[7:0]);
      end
      req(q, r, 1'b0);
    end
    // counts 0 and 17, then past the register space
    q = {ME, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    r = {ME, 8'h83, 8'h03};
    req(q, r, 1'b0);
    q[5] = 8'h11;
    req(q, r, 1'b0);
    q = {ME, 8'h03, 8'h00, 8'h7F, 8'h00, 8'h02};
    r[2] = 8'h02;
    req(q, r, 1'b0);
    a = $urandom_range(0, 119);
    v = 16'($urandom);
    q = {ME, 8'h06, 8'h00, 8'(a), v[15:8], v[7:0]};
    req(q, q, 1'b0);
    chk("wr_single", u_master.wr_q[$], {16'(a), v});
    u_master.wr_q.delete();
    err_on <= 1'b1;
    q = {ME, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
    r = {ME, 8'h86, 8'h04};
    req(q, r, 1'b0);
    err_on <= 1'b0;
    u_master.wr_q.delete();
    s = $urandom_range(0, 118);
    q = {ME, 8'h10, 8'h00, 8'(s), 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], ~v[15:8], ~v[7:0]};
    r = {ME, 8'h10, 8'h00, 8'(s), 8'h00, 8'h02};
    req(q, r, 1'b0);
    chk("wr_count", u_master.wr_q.size(), 2);
    chk("wr_word0", u_master.wr_q[0], {16'(s), v});
    chk("wr_word1", u_master.wr_q[1], {16'(s + 1), ~v});
    q = {ME, 8'h10, 8'h00, 8'h00, 8'h00, 8'h03, 8'h06, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    r = {ME, 8'h90, 8'h03};
    req(q, r, 1'b0);
    fcs = '{8'h01, 8'h04, 8'h2B};
    foreach (fcs[i]) begin
      q = {ME, fcs[i], 8'h00, 8'h00, 8'h00, 8'h01};
      r = {ME, fcs[i] | 8'h80, 8'h01};
      req(q, r, 1'b0);
    end
    // foreign address and bad check word
    q = {8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    req(q, e, 1'b0);
    q[0] = ME;
    req(q, e, 1'b1);
    q = {ME, 8'h06, 8'h00, 8'h78, 8'hC1, 8'hC0};
    req(q, q, 1'b0);
    chk("save_count", save_n, 1);
    q[5] = 8'hA0;
    req(q, q, 1'b0);
    chk("boot_count", boot_n, 1);
    chk("addr_after_boot", slave_addr, ME);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      fail_cond <= 8'($urandom);
      fail_mask <= (k == 0) ? 8'h00 : 8'($urandom);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("led_fail", led_fail, |(fail_cond & fail_mask));
    end
    wrap_up();
  end
endmodule
